//--- verilog/cce_pkg.sv
// constants and types shared by the charger control and event block
// Notes on behaviour
// - a short on the third general-purpose regulator turns it off and flags it
// - serial path with a dead battery: switch open while trickling, closed once charged
// - input over-voltage opens both charge-path pass transistors at once
// - reverse supply bit set makes all three path transistors conduct except during input over-voltage, clear keeps it off
// - override clear lets hardware drive the battery switch, set hands it to software
// - under override, level bit 0 drives the switch output high and 1 drives it low
// - two-bit power limiter setting plus a disable bit, limiter active while bit is 0
// - charge LED output is driven only while its enable bit is 1
// - mode bit 0 selects standalone charging, 1 selects software-controlled charging
// - a separate bit applies software voltage and current codes in standalone mode
// - cycling bit 0 lets charging resume after completion, 1 forbids it
// - writing the restart control restarts the charger state machine
// - software holds a 3-bit voltage code and 4-bit current code applied to the regulator
// - a control bit enables or disables the trickle charge current source
// - a control bit makes out-of-range battery temperature be ignored
// - fault interrupt on over-voltage, dissipation, timeout or temperature, with kind field
// - separate attach, usb over-voltage, wall and reverse-short flags plus two sense bits
// - reverse and charge current flags come from the 35 mA current comparator
// - the 98 percent cycle threshold restarts charging and drives the mode flag
// - path sense bit reads 1 for a serial path and 0 for a single path
// - the 3.0 V battery minimum raises the current step and spots a dead battery
// - the 3.2 V and 3.4 V thresholds close the battery switch in serial path
// - over-voltage raises the fault flag, which has its own mask, with kind 01
package cce_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CHG_CFG = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PATH_CFG = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_SENSE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_GP3 = 8'h14;
  // charge configuration fields
  localparam int CHG_VOLT_LSB = 0;
  localparam int CHG_CURR_LSB = 3;
  localparam int CHG_TRICKLE = 7;
  localparam int CHG_THERM_OFF = 8;
  localparam logic [2:0] RST_VOLT = 3'h3;
  localparam logic [3:0] RST_CURR = 4'h6;
  localparam logic RST_TRICKLE = 1'b1;
  // path configuration fields
  localparam int PTH_OVRD = 0;
  localparam int PTH_LEVEL = 1;
  localparam int PTH_REVERSE = 2;
  localparam int PTH_PLIM_LSB = 3;
  localparam int PTH_PLIM_OFF = 5;
  localparam int PTH_LED_EN = 6;
  localparam int PTH_SW_SEL = 7;
  localparam int PTH_SA_SW = 8;
  localparam int PTH_CYCL_OFF = 9;
  localparam int PTH_RESTART = 10;
  // third regulator fields
  localparam int GP3_EN = 0;
  localparam int GP3_PASS = 1;
  localparam int GP3_VSEL = 2;
  // sense fields
  localparam int SNS_KIND_LSB = 0;
  localparam int SNS_CHG_EN = 2;
  localparam int SNS_WALL = 3;
  localparam int SNS_PATH = 4;
  localparam int SNS_GP3_ON = 5;
  localparam int SNS_CURR = 6;
  localparam int SNS_BMIN = 7;
  localparam int SNS_SYSON = 8;
  localparam int SNS_BON = 9;
  localparam int SNS_CYCL = 10;
  localparam int SNS_STATE_LSB = 11;
  // event flag positions
  localparam int NUM_EV = 9;
  localparam int EV_ATTACH = 0;
  localparam int EV_FAULT = 1;
  localparam int EV_USB_OV = 2;
  localparam int EV_REV_SHORT = 3;
  localparam int EV_REV_CURR = 4;
  localparam int EV_CURR_THR = 5;
  localparam int EV_REG_MODE = 6;
  localparam int EV_WALL = 7;
  localparam int EV_SHORT = 8;
  localparam logic [NUM_EV-1:0] RST_MASK = 9'h1FF;
  // standalone regulator codes
  localparam logic [2:0] SA_VOLT = 3'h3;
  localparam logic [3:0] SA_CURR = 4'h6;
  localparam logic [3:0] PRE_CURR = 4'h1;
  localparam logic [3:0] CURR_OFF = 4'h0;
  typedef enum logic [1:0] {
    FK_NONE = 2'b00,
    FK_OVERVOLT = 2'b01,
    FK_TEMP = 2'b10,
    FK_POWER = 2'b11
  } cce_fault_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CHARGE = 2'b01,
    ST_DONE = 2'b11,
    ST_FAULT = 2'b10
  } cce_state_e;
endpackage

//--- verilog/cce_evt_if.sv
// event, clear and mask signals between the control logic and its flag bank
`timescale 1ns/1ps
interface cce_evt_if;
  import cce_pkg::*;
  logic [NUM_EV-1:0] ev;
  logic [NUM_EV-1:0] clr;
  logic [NUM_EV-1:0] mask;
  logic [NUM_EV-1:0] flags;
  logic irq;
  modport bank (input ev, input clr, input mask, output flags, output irq);
  modport ctrl (output ev, output clr, output mask, input flags, input irq);
endinterface

//--- verilog/cce_sync.sv
// three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module cce_sync #(
  parameter int W = 1
) (
  input wire logic clock_i, // system clock
  input wire logic rst_n_i, // synchronised reset, active low
  input wire logic [W-1:0] d_i, // asynchronous levels
  output logic [W-1:0] q_o // filtered levels
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] q_reg;
  genvar g;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          q_reg[g] <= 1'b0;
        end else if (s2_reg[g] == s3_reg[g]) begin
          q_reg[g] <= s3_reg[g];
        end
      end
    end
  endgenerate
  assign q_o = q_reg;
endmodule

//--- verilog/cce_evt_bank.sv
// sticky event flags with clear-by-write-one and a masked interrupt summary
`timescale 1ns/1ps
module cce_evt_bank (
  input wire logic clock_i, // system clock
  input wire logic rst_n_i, // synchronised reset, active low
  cce_evt_if.bank evt // events, clears, mask and flags
);
  import cce_pkg::*;
  logic [NUM_EV-1:0] flags_reg;
  // a new event in the clearing cycle keeps its flag
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= (flags_reg & ~evt.clr) | evt.ev;
    end
  end
  assign evt.flags = flags_reg;
  assign evt.irq = |(flags_reg & ~evt.mask);
endmodule

//--- verilog/cce_top.sv
// charger control bits, path switching and event flags behind an AHB-Lite slave
`timescale 1ns/1ps
module cce_top (
  input wire logic clock_i, // 50 MHz system clock
  input wire logic arst_n_i, // asynchronous reset, active low
  input wire logic hsel_i, // slave select
  input wire logic [cce_pkg::ADDR_W-1:0] haddr_i, // byte address
  input wire logic [1:0] htrans_i, // transfer type
  input wire logic hwrite_i, // write when high
  input wire logic [2:0] hsize_i, // transfer size
  input wire logic [31:0] hwdata_i, // write data
  input wire logic hready_i, // bus ready
  output logic [31:0] hrdata_o, // read data
  output logic hreadyout_o, // slave ready
  output logic hresp_o, // response, always okay
  input wire logic charger_present_i, // charger attached
  input wire logic charger_ovp_i, // charger input over-voltage
  input wire logic power_fault_i, // excessive dissipation
  input wire logic charge_timeout_i, // charge timer expired
  input wire logic batt_temp_bad_i, // thermistor out of range
  input wire logic usb_overvolt_i, // usb over-voltage
  input wire logic reverse_short_i, // short on the reverse supply
  input wire logic wall_detect_n_i, // wall charger pin, low when wall
  input wire logic path_serial_i, // serial path strap
  input wire logic current_comparator_level_i, // above 35 mA
  input wire logic battery_min_level_i, // battery above 3.0 V
  input wire logic sys_supply_on_level_i, // system supply above 3.2 V
  input wire logic battery_on_level_i, // battery above 3.4 V
  input wire logic recharge_cycle_level_i, // above 98 percent of set voltage
  input wire logic gp3_short_i, // third regulator short circuit
  output logic [2:0] charge_volt_code_o, // applied voltage code
  output logic [3:0] charge_current_code_o, // applied current code
  output logic trickle_enable_o, // trickle source on
  output logic pass_main_on_o, // both pass transistors conduct
  output logic batt_switch_out_o, // battery switch drive, low conducts
  output logic [1:0] power_limit_setting_o, // limiter setting
  output logic power_limit_on_o, // limiter active
  output logic charge_led_out_o, // charge indicator
  output logic gp3_enable_o, // third regulator on
  output logic gp3_pass_select_o, // external pass device
  output logic gp3_volt_sel_o, // third regulator voltage
  output logic irq_o // unmasked flag pending
);
  import cce_pkg::*;

  function automatic logic cce_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    cce_hit = (a == ofs);
  endfunction

  logic rst_ff1_reg;
  logic rst_n;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_ff1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_ff1_reg <= 1'b1;
      rst_n <= rst_ff1_reg;
    end
  end

  // pins from the analog side
  localparam int NPIN = 15;
  logic [NPIN-1:0] pin_q;
  wire present;
  wire ovp;
  wire pwr_flt;
  wire tmo;
  wire temp_bad;
  wire usb_ov;
  wire rev_sc;
  wire wall;
  wire serial;
  wire curr_lvl;
  wire bmin;
  wire sys_on;
  wire bat_on;
  wire cyc_lvl;
  wire gp3_sc;
  cce_sync #(.W(NPIN)) u_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n),
    .d_i({charger_present_i, charger_ovp_i, power_fault_i, charge_timeout_i, batt_temp_bad_i,
          usb_overvolt_i, reverse_short_i, ~wall_detect_n_i, path_serial_i, current_comparator_level_i,
          battery_min_level_i, sys_supply_on_level_i, battery_on_level_i, recharge_cycle_level_i,
          gp3_short_i}),
    .q_o(pin_q)
  );
  assign {present, ovp, pwr_flt, tmo, temp_bad, usb_ov, rev_sc, wall, serial, curr_lvl,
          bmin, sys_on, bat_on, cyc_lvl, gp3_sc} = pin_q;

  // bus slave, zero wait states
  logic dp_valid_reg;
  logic dp_write_reg;
  logic [ADDR_W-1:0] dp_addr_reg;
  wire addr_phase = hsel_i & htrans_i[1] & hready_i;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_addr_reg <= '0;
    end else if (hready_i) begin
      dp_valid_reg <= addr_phase;
      dp_write_reg <= hwrite_i;
      dp_addr_reg <= {haddr_i[ADDR_W-1:2], 2'b00};
    end
  end
  wire wr = dp_valid_reg & dp_write_reg;
  wire wr_chg = wr & cce_hit(dp_addr_reg, OFS_CHG_CFG);
  wire wr_path = wr & cce_hit(dp_addr_reg, OFS_PATH_CFG);
  wire wr_stat = wr & cce_hit(dp_addr_reg, OFS_IRQ_STAT);
  wire wr_mask = wr & cce_hit(dp_addr_reg, OFS_IRQ_MASK);
  wire wr_gp3 = wr & cce_hit(dp_addr_reg, OFS_GP3);

  // software configuration
  logic [2:0] cfg_volt_reg;
  logic [3:0] cfg_curr_reg;
  logic trickle_reg;
  logic therm_off_reg;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg_volt_reg <= RST_VOLT;
      cfg_curr_reg <= RST_CURR;
      trickle_reg <= RST_TRICKLE;
      therm_off_reg <= 1'b0;
    end else if (wr_chg) begin
      cfg_volt_reg <= hwdata_i[CHG_VOLT_LSB +: 3];
      cfg_curr_reg <= hwdata_i[CHG_CURR_LSB +: 4];
      trickle_reg <= hwdata_i[CHG_TRICKLE];
      therm_off_reg <= hwdata_i[CHG_THERM_OFF];
    end
  end

  logic ovrd_reg;
  logic level_reg;
  logic reverse_reg;
  logic [1:0] plim_reg;
  logic plim_off_reg;
  logic led_en_reg;
  logic sw_sel_reg;
  logic sa_sw_reg;
  logic cycl_off_reg;
  logic restart_reg;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ovrd_reg <= 1'b0;
      level_reg <= 1'b0;
      reverse_reg <= 1'b0;
      plim_reg <= 2'b00;
      plim_off_reg <= 1'b0;
      led_en_reg <= 1'b0;
      sw_sel_reg <= 1'b0;
      sa_sw_reg <= 1'b0;
      cycl_off_reg <= 1'b0;
    end else if (wr_path) begin
      ovrd_reg <= hwdata_i[PTH_OVRD];
      level_reg <= hwdata_i[PTH_LEVEL];
      reverse_reg <= hwdata_i[PTH_REVERSE];
      plim_reg <= hwdata_i[PTH_PLIM_LSB +: 2];
      plim_off_reg <= hwdata_i[PTH_PLIM_OFF];
      led_en_reg <= hwdata_i[PTH_LED_EN];
      sw_sel_reg <= hwdata_i[PTH_SW_SEL];
      sa_sw_reg <= hwdata_i[PTH_SA_SW];
      cycl_off_reg <= hwdata_i[PTH_CYCL_OFF];
    end
  end

  // restart is a self-clearing strobe
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= wr_path & hwdata_i[PTH_RESTART];
    end
  end

  logic [NUM_EV-1:0] mask_reg;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      mask_reg <= RST_MASK;
    end else if (wr_mask) begin
      mask_reg <= hwdata_i[NUM_EV-1:0];
    end
  end

  // third regulator: a short wins over a software write in the same cycle only if the regulator is already on
  logic gp3_en_reg;
  logic gp3_pass_reg;
  logic gp3_vsel_reg;
  logic gp3_prev_reg;
  wire gp3_trip = gp3_sc & ~gp3_prev_reg & gp3_en_reg;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      gp3_en_reg <= 1'b0;
      gp3_pass_reg <= 1'b0;
      gp3_vsel_reg <= 1'b0;
    end else begin
      if (gp3_trip) begin
        gp3_en_reg <= 1'b0;
      end else if (wr_gp3) begin
        gp3_en_reg <= hwdata_i[GP3_EN];
      end
      if (wr_gp3) begin
        gp3_pass_reg <= hwdata_i[GP3_PASS];
        gp3_vsel_reg <= hwdata_i[GP3_VSEL];
      end
    end
  end

  // charger sequencing and fault capture
  cce_state_e state_reg;
  cce_state_e state_next;
  cce_fault_e kind_reg;
  wire temp_flt = temp_bad & ~therm_off_reg;
  wire fault_any = ovp | pwr_flt | tmo | temp_flt;
  wire eoc = ~curr_lvl & cyc_lvl;
  wire resume = ~cyc_lvl & ~cycl_off_reg;
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (fault_any) begin
          state_next = ST_FAULT;
        end else if (present) begin
          state_next = ST_CHARGE;
        end
      end
      ST_CHARGE: begin
        if (fault_any) begin
          state_next = ST_FAULT;
        end else if (!present) begin
          state_next = ST_IDLE;
        end else if (eoc) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        if (fault_any) begin
          state_next = ST_FAULT;
        end else if (!present) begin
          state_next = ST_IDLE;
        end else if (resume) begin
          state_next = ST_CHARGE;
        end
      end
      ST_FAULT: begin
        if (!fault_any) begin
          state_next = ST_IDLE;
        end
      end
    endcase
    if (restart_reg) begin
      state_next = ST_IDLE;
    end
  end
  wire [1:0] kind_next = ovp ? FK_OVERVOLT : (temp_flt ? FK_TEMP : ((pwr_flt | tmo) ? FK_POWER : FK_NONE));
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      kind_reg <= FK_NONE;
    end else begin
      state_reg <= state_next;
      kind_reg <= cce_fault_e'(kind_next);
    end
  end
  wire charging = (state_reg == ST_CHARGE);

  // applied regulator settings
  wire use_sw = sw_sel_reg | sa_sw_reg;
  wire [3:0] sa_curr = bmin ? SA_CURR : PRE_CURR;
  wire [3:0] curr_sel = use_sw ? cfg_curr_reg : sa_curr;
  wire [2:0] volt_sel = use_sw ? cfg_volt_reg : SA_VOLT;
  wire rev_on = reverse_reg & ~ovp;
  wire hw_close = rev_on | ~serial | (bat_on & sys_on);
  wire sw_out = ovrd_reg ? ~level_reg : ~hw_close;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      charge_volt_code_o <= SA_VOLT;
      charge_current_code_o <= CURR_OFF;
      trickle_enable_o <= 1'b0;
      batt_switch_out_o <= 1'b1;
      charge_led_out_o <= 1'b0;
    end else begin
      charge_volt_code_o <= volt_sel;
      charge_current_code_o <= charging ? curr_sel : CURR_OFF;
      trickle_enable_o <= trickle_reg & present & ~ovp & ~bat_on;
      batt_switch_out_o <= sw_out;
      charge_led_out_o <= led_en_reg & charging;
    end
  end
  // pass transistors react to over-voltage without a register stage
  assign pass_main_on_o = ~ovp & (charging | rev_on);
  assign power_limit_setting_o = plim_reg;
  assign power_limit_on_o = ~plim_off_reg;
  assign gp3_enable_o = gp3_en_reg;
  assign gp3_pass_select_o = gp3_pass_reg;
  assign gp3_volt_sel_o = gp3_vsel_reg;

  // edge detection of the synchronised levels
  logic present_prev_reg;
  logic usb_prev_reg;
  logic rev_prev_reg;
  logic curr_prev_reg;
  logic wall_prev_reg;
  logic cyc_prev_reg;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      present_prev_reg <= 1'b0;
      usb_prev_reg <= 1'b0;
      rev_prev_reg <= 1'b0;
      curr_prev_reg <= 1'b0;
      wall_prev_reg <= 1'b0;
      cyc_prev_reg <= 1'b0;
      gp3_prev_reg <= 1'b0;
    end else begin
      present_prev_reg <= present;
      usb_prev_reg <= usb_ov;
      rev_prev_reg <= rev_sc;
      curr_prev_reg <= curr_lvl;
      wall_prev_reg <= wall;
      cyc_prev_reg <= cyc_lvl;
      gp3_prev_reg <= gp3_sc;
    end
  end

  cce_evt_if u_evt ();
  assign u_evt.ev[EV_ATTACH] = present & ~present_prev_reg;
  assign u_evt.ev[EV_FAULT] = (state_next == ST_FAULT) & (state_reg != ST_FAULT);
  assign u_evt.ev[EV_USB_OV] = usb_ov & ~usb_prev_reg;
  assign u_evt.ev[EV_REV_SHORT] = rev_sc & ~rev_prev_reg & reverse_reg;
  assign u_evt.ev[EV_REV_CURR] = ~curr_lvl & curr_prev_reg & charging;
  assign u_evt.ev[EV_CURR_THR] = curr_lvl & ~curr_prev_reg;
  assign u_evt.ev[EV_REG_MODE] = cyc_lvl ^ cyc_prev_reg;
  assign u_evt.ev[EV_WALL] = wall & ~wall_prev_reg;
  assign u_evt.ev[EV_SHORT] = gp3_trip;
  assign u_evt.clr = wr_stat ? hwdata_i[NUM_EV-1:0] : '0;
  assign u_evt.mask = mask_reg;
  cce_evt_bank u_bank (
    .clock_i(clock_i),
    .rst_n_i(rst_n),
    .evt(u_evt)
  );
  assign irq_o = u_evt.irq;

  // read-back words
  logic [31:0] chg_word;
  logic [31:0] path_word;
  logic [31:0] sense_word;
  logic [31:0] gp3_word;
  always_comb begin
    chg_word = '0;
    chg_word[CHG_VOLT_LSB +: 3] = cfg_volt_reg;
    chg_word[CHG_CURR_LSB +: 4] = cfg_curr_reg;
    chg_word[CHG_TRICKLE] = trickle_reg;
    chg_word[CHG_THERM_OFF] = therm_off_reg;
    path_word = '0;
    path_word[PTH_OVRD] = ovrd_reg;
    path_word[PTH_LEVEL] = level_reg;
    path_word[PTH_REVERSE] = reverse_reg;
    path_word[PTH_PLIM_LSB +: 2] = plim_reg;
    path_word[PTH_PLIM_OFF] = plim_off_reg;
    path_word[PTH_LED_EN] = led_en_reg;
    path_word[PTH_SW_SEL] = sw_sel_reg;
    path_word[PTH_SA_SW] = sa_sw_reg;
    path_word[PTH_CYCL_OFF] = cycl_off_reg;
    sense_word = '0;
    sense_word[SNS_KIND_LSB +: 2] = kind_reg;
    sense_word[SNS_CHG_EN] = charging;
    sense_word[SNS_WALL] = ~wall;
    sense_word[SNS_PATH] = serial;
    sense_word[SNS_GP3_ON] = gp3_en_reg;
    sense_word[SNS_CURR] = curr_lvl;
    sense_word[SNS_BMIN] = bmin;
    sense_word[SNS_SYSON] = sys_on;
    sense_word[SNS_BON] = bat_on;
    sense_word[SNS_CYCL] = cyc_lvl;
    sense_word[SNS_STATE_LSB +: 2] = state_reg;
    gp3_word = '0;
    gp3_word[GP3_EN] = gp3_en_reg;
    gp3_word[GP3_PASS] = gp3_pass_reg;
    gp3_word[GP3_VSEL] = gp3_vsel_reg;
  end
  wire [31:0] stat_word = {{(32 - NUM_EV){1'b0}}, u_evt.flags};
  wire [31:0] mask_word = {{(32 - NUM_EV){1'b0}}, mask_reg};
  wire [31:0] rd_word =
    cce_hit(dp_addr_reg, OFS_CHG_CFG) ? chg_word :
    cce_hit(dp_addr_reg, OFS_PATH_CFG) ? path_word :
    cce_hit(dp_addr_reg, OFS_IRQ_STAT) ? stat_word :
    cce_hit(dp_addr_reg, OFS_IRQ_MASK) ? mask_word :
    cce_hit(dp_addr_reg, OFS_SENSE) ? sense_word :
    cce_hit(dp_addr_reg, OFS_GP3) ? gp3_word : 32'h0000_0000;
  assign hrdata_o = (dp_valid_reg & ~dp_write_reg) ? rd_word : 32'h0000_0000;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
endmodule

//--- testbench/cce_top_monitor.sv
// port assertions for the charger control block
`timescale 1ns/1ps
module cce_top_monitor (
  input wire logic clock_i, // clock
  input wire logic arst_n_i, // reset
  input wire logic hsel_i, // select
  input wire logic [1:0] htrans_i, // trans
  input wire logic hwrite_i, // write
  input wire logic hready_i, // ready
  input wire logic [31:0] hrdata_o, // rdata
  input wire logic hreadyout_o, // ready out
  input wire logic hresp_o, // resp
  input wire logic charger_present_i, // charger
  input wire logic charger_ovp_i, // ovp
  input wire logic gp3_short_i, // short
  input wire logic gp3_enable_o, // gp3 on
  input wire logic trickle_enable_o, // trickle
  input wire logic pass_main_on_o, // pass
  input wire logic [2:0] charge_volt_code_o, // volt
  input wire logic [1:0] power_limit_setting_o, // limit
  input wire logic power_limit_on_o // limiter
);
  logic rd_q;
  logic wr_q;
  always_ff @(posedge clock_i) begin
    rd_q <= hsel_i && htrans_i[1] && hready_i && !hwrite_i;
    wr_q <= hsel_i && htrans_i[1] && hready_i && hwrite_i;
  end
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!arst_n_i);
  sequence s_short;
    gp3_enable_o && $rose(gp3_short_i) ##1 gp3_short_i [*5];
  endsequence
  AST_BUS_OKAY: assert property (hreadyout_o && !hresp_o)
    else $error("bus response not okay");
  AST_RDATA_IDLE: assert property (!rd_q |-> hrdata_o == 32'h0000_0000)
    else $error("read data outside read phase");
  AST_OVP_PASS: assert property (charger_ovp_i [*6] |-> !pass_main_on_o)
    else $error("pass path on during overvoltage");
  AST_OVP_TRICKLE: assert property (charger_ovp_i [*6] |-> !trickle_enable_o)
    else $error("trickle on during overvoltage");
  AST_IDLE_TRICKLE: assert property (!charger_present_i [*6] |-> !trickle_enable_o)
    else $error("trickle on without charger");
  AST_GP3_SHORT: assert property (s_short |=> !gp3_enable_o)
    else $error("regulator kept on after short");
  AST_VOLT_WRITE: assert property ($changed(charge_volt_code_o) |-> $past(wr_q) || $past(wr_q, 2))
    else $error("voltage code moved without a write");
  AST_LIMIT_WRITE: assert property ($changed({power_limit_on_o, power_limit_setting_o}) |-> $past(wr_q) || $past(wr_q, 2))
    else $error("limiter moved without a write");
endmodule
bind cce_top cce_top_monitor cce_top_monitor_inst (.clock_i, .arst_n_i, .hsel_i, .htrans_i, .hwrite_i, .hready_i,
  .hrdata_o, .hreadyout_o, .hresp_o, .charger_present_i, .charger_ovp_i, .gp3_short_i, .gp3_enable_o,
  .trickle_enable_o, .pass_main_on_o, .charge_volt_code_o, .power_limit_setting_o, .power_limit_on_o);

//--- testbench/cce_host_model.sv
// host model that issues single AHB-Lite word transfers
`timescale 1ns/1ps
module cce_host_model (
  input wire logic clock_i, // clock
  input wire logic hready_i, // ready
  input wire logic [31:0] hrdata_i, // read data
  output logic hsel_o, // select
  output logic [cce_pkg::ADDR_W-1:0] haddr_o, // address
  output logic [1:0] htrans_o, // transfer type
  output logic hwrite_o, // write
  output logic [31:0] hwdata_o // write data
);
  import cce_pkg::*;
  initial begin
    hsel_o = 1'b0;
    haddr_o = '0;
    htrans_o = 2'b00;
    hwrite_o = 1'b0;
    hwdata_o = 32'h0000_0000;
  end
  // each phase is held until ready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic ok);
    int n;
    n = 0;
    @(posedge clock_i);
    hsel_o <= 1'b1;
    haddr_o <= a;
    htrans_o <= 2'b10;
    hwrite_o <= w;
    do @(posedge clock_i); while (!hready_i && ++n < 64);
    hsel_o <= 1'b0;
    htrans_o <= 2'b00;
    hwdata_o <= d;
    do @(posedge clock_i); while (!hready_i && ++n < 64);
    q = hrdata_i;
    ok = n < 64;
  endtask
endmodule

//--- testbench/tb_top.sv
// self-checking bench for the charger control block
`timescale 1ns/1ps
module tb_top;
  import cce_pkg::*;
  logic clock_i;
  logic arst_n_i;
  logic [14:0] lv;
  logic [31:0] q;
  logic hsel, hwrite, hready, hresp, trk, pass, bsw, plon, led, gen, gps, gvs, irq;
  logic [ADDR_W-1:0] haddr;
  logic [1:0] htrans, plim;
  logic [31:0] hwdata, hrdata;
  logic [2:0] volt;
  logic [3:0] curr;
  int fail_count;
  int total_checks;
  cce_host_model cce_host_model_inst (.clock_i, .hready_i(hready), .hrdata_i(hrdata), .hsel_o(hsel),
    .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hwdata_o(hwdata));
  cce_top cce_top_inst (.clock_i, .arst_n_i, .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .charger_present_i(lv[0]), .charger_ovp_i(lv[1]),
    .power_fault_i(lv[2]), .charge_timeout_i(lv[3]), .batt_temp_bad_i(lv[4]), .usb_overvolt_i(lv[5]),
    .reverse_short_i(lv[6]), .wall_detect_n_i(lv[7]), .path_serial_i(lv[8]),
    .current_comparator_level_i(lv[9]), .battery_min_level_i(lv[10]), .sys_supply_on_level_i(lv[11]),
    .battery_on_level_i(lv[12]), .recharge_cycle_level_i(lv[13]), .gp3_short_i(lv[14]),
    .charge_volt_code_o(volt), .charge_current_code_o(curr), .trickle_enable_o(trk), .pass_main_on_o(pass),
    .batt_switch_out_o(bsw), .power_limit_setting_o(plim), .power_limit_on_o(plon), .charge_led_out_o(led),
    .gp3_enable_o(gen), .gp3_pass_select_o(gps), .gp3_volt_sel_o(gvs), .irq_o(irq));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic ok;
    cce_host_model_inst.xfer(w, a, d, q, ok);
    if (!ok) begin
      fail_count++;
      finish_test();
    end
    if (w) begin
      repeat (8) @(posedge clock_i);
    end
  endtask
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  initial begin
    arst_n_i = 1'b0;
    lv = 15'h0480;
    fail_count = 0;
    total_checks = 0;
    repeat (6) @(posedge clock_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    bus(1'b0, OFS_CHG_CFG, 32'h0);
    chk("chg_cfg", q, 32'hB3);
    bus(1'b0, OFS_IRQ_MASK, 32'h0);
    chk("mask", q, 32'h1FF);
    bus(1'b1, OFS_CHG_CFG, 32'hAD);
    chk("volt", volt, 32'h3);
    bus(1'b0, OFS_CHG_CFG, 32'h0);
    chk("chg_cfg", q, 32'hAD);
    bus(1'b1, OFS_PATH_CFG, 32'h80);
    chk("volt", volt, 32'h5);
    bus(1'b1, OFS_PATH_CFG, 32'h100);
    chk("volt", volt, 32'h5);
    bus(1'b1, OFS_PATH_CFG, 32'h1);
    chk("switch", bsw, 32'h1);
    bus(1'b1, OFS_PATH_CFG, 32'h3);
    chk("switch", bsw, 32'h0);
    bus(1'b1, OFS_PATH_CFG, 32'h10);
    chk("limit", {plon, plim}, 32'h6);
    bus(1'b1, OFS_PATH_CFG, 32'h430);
    chk("limit", {plon, plim}, 32'h2);
    bus(1'b0, OFS_PATH_CFG, 32'h0);
    chk("path", q, 32'h30);
    bus(1'b1, 8'h18, 32'hFFFF_FFFF);
    bus(1'b0, 8'h18, 32'h0);
    chk("unmapped", q, 32'h0);
    bus(1'b1, OFS_PATH_CFG, 32'h40);
    bus(1'b1, OFS_IRQ_MASK, 32'h1FE);
    lv[0] <= 1'b1;
    lv[8] <= 1'b1;
    repeat (8) @(posedge clock_i);
    chk("irq", irq, 32'h1);
    chk("led", led, 32'h1);
    chk("trickle", trk, 32'h1);
    chk("switch", bsw, 32'h1);
    chk("current", curr, 32'h6);
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("flags", q, 32'h1);
    bus(1'b1, OFS_IRQ_STAT, 32'h1);
    chk("irq", irq, 32'h0);
    bus(1'b0, OFS_SENSE, 32'h0);
    chk("sense", q[4:2], 32'h7);
    lv[10] <= 1'b0;
    repeat (8) @(posedge clock_i);
    chk("current", curr, 32'h1);
    lv[12:11] <= 2'b11;
    repeat (8) @(posedge clock_i);
    chk("trickle", trk, 32'h0);
    chk("switch", bsw, 32'h0);
    bus(1'b1, OFS_PATH_CFG, 32'h0);
    chk("led", led, 32'h0);
    chk("pass", pass, 32'h1);
    bus(1'b1, OFS_IRQ_MASK, 32'h0);
    lv[1] <= 1'b1;
    repeat (8) @(posedge clock_i);
    chk("pass", pass, 32'h0);
    bus(1'b0, OFS_SENSE, 32'h0);
    chk("kind", q[1:0], 32'h1);
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("fault", q[1], 32'h1);
    bus(1'b1, OFS_GP3, 32'h7);
    chk("gp3", {gvs, gps, gen}, 32'h7);
    lv[14] <= 1'b1;
    repeat (8) @(posedge clock_i);
    chk("gp3", {gvs, gps, gen}, 32'h6);
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("short", q[8], 32'h1);
    finish_test();
  end
endmodule
